// ===== include/nep_consts.vh
// Constants for the chip-select-two single-bit ECC parity block
`ifndef NEP_CONSTS_VH
`define NEP_CONSTS_VH
// Printed offsets are word indexes; byte address is four times the index
`define NEP_IDX_EVEN        16'h1070
`define NEP_IDX_ODD         16'h1071
`define NEP_IDX_CTRL        16'h1060
`define NEP_BYTE_EVEN       18'h0_41C0
`define NEP_BYTE_ODD        18'h0_41C4
`define NEP_BYTE_CTRL       18'h0_4180
`define NEP_ADDR_W          18
`define NEP_PAR_MSB         11
`define NEP_PAR_W           12
`define NEP_PAR_RESET       12'h000
`define NEP_CTRL_NAND_BIT   0
`define NEP_CTRL_START_BIT  8
`define NEP_CTRL_WIDE_BIT   9
`define NEP_NAND_RESET      1'b1
`define NEP_COL8_BITS       3
`define NEP_COL16_BITS      4
`endif

// ===== rtl/nep_ecc_parity.v
// APB register block holding chip-select-two single-bit ECC parities
`timescale 1ns/1ps
`default_nettype none
`include "nep_consts.vh"
module nep_ecc_parity (
   input  wire                   pclk,
   input  wire                   presetn,
   input  wire                   psel,
   input  wire                   penable,
   input  wire                   pwrite,
   input  wire [`NEP_ADDR_W-1:0] paddr,
   input  wire [31:0]            pwdata,
   output reg  [31:0]            prdata,
   output reg                    pready,
   output reg                    pslverr,
   input  wire                   memory_select_two,
   input  wire                   data_strobe,
   input  wire [15:0]            nand_data,
   output reg                    select_two_nand_enable,
   output reg                    select_two_parity_start
);
   // ----------------------------------------------------------------
   // Register selection
   // ----------------------------------------------------------------
   localparam [1:0] SEL_NONE = 2'b00;
   localparam [1:0] SEL_EVEN = 2'b01;
   localparam [1:0] SEL_ODD  = 2'b10;
   localparam [1:0] SEL_CTRL = 2'b11;

   // Unlisted addresses fall to SEL_NONE and are refused
   function [1:0] decode_reg;
      input [`NEP_ADDR_W-1:0] addr;
      begin
         if (addr == `NEP_BYTE_EVEN)
            decode_reg = SEL_EVEN;
         else if (addr == `NEP_BYTE_ODD)
            decode_reg = SEL_ODD;
         else if (addr == `NEP_BYTE_CTRL)
            decode_reg = SEL_CTRL;
         else
            decode_reg = SEL_NONE;
      end
   endfunction

   // Either parity register; a read of one ends a calculation
   function is_parity;
      input [1:0] sel;
      begin
         is_parity = (sel == SEL_EVEN) || (sel == SEL_ODD);
      end
   endfunction

   // Reserved bits always read as zero
   function [31:0] read_word;
      input [1:0]            sel;
      input [`NEP_PAR_MSB:0] even;
      input [`NEP_PAR_MSB:0] odd;
      input                  wide;
      input                  start;
      input                  nand_en;
      begin
         read_word = 32'h0000_0000;
         if (is_parity(sel)) begin
            if (sel == SEL_EVEN)
               read_word[`NEP_PAR_MSB:0] = even;
            else
               read_word[`NEP_PAR_MSB:0] = odd;
         end else if (sel == SEL_CTRL) begin
            // Control word readback for software
            read_word[`NEP_CTRL_NAND_BIT]  = nand_en;
            read_word[`NEP_CTRL_START_BIT] = start;
            read_word[`NEP_CTRL_WIDE_BIT]  = wide;
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   reg  [`NEP_PAR_MSB:0] even_par;
   reg  [`NEP_PAR_MSB:0] odd_par;
   reg                   bus_wide;
   reg  [10:0]           word_index;
   reg  [`NEP_PAR_MSB:0] next_even_par;
   reg  [`NEP_PAR_MSB:0] next_odd_par;
   reg  [10:0]           next_word_index;
   reg                   next_start;

   wire [`NEP_PAR_MSB:0] word_even;
   wire [`NEP_PAR_MSB:0] word_odd;
   wire [1:0]            reg_sel;
   wire                  setup;
   wire                  access;
   wire                  wr;
   wire                  rd;
   wire                  ctrl_wr;
   wire                  start_req;
   wire                  clear_start;
   wire                  take_word;

   // Writes and the start clear act only in the access phase
   assign reg_sel     = decode_reg(paddr);
   assign setup       = psel && !penable;
   assign access      = psel && penable;
   assign wr          = access && pwrite;
   assign rd          = access && !pwrite;
   assign ctrl_wr     = wr && (reg_sel == SEL_CTRL);
   assign start_req   = ctrl_wr && pwdata[`NEP_CTRL_START_BIT];
   assign clear_start = rd && is_parity(reg_sel);
   // Only words on a NAND-mapped select two count, and only once started
   assign take_word   = data_strobe && memory_select_two && select_two_nand_enable
                        && select_two_parity_start;

   // ----------------------------------------------------------------
   // Parity arithmetic
   // ----------------------------------------------------------------
   // Column bits are the low 3 or 4 address bits, chosen by bus width
   nep_parity_calc nep_parity_calc_inst (
      .data       (nand_data),
      .wide       (bus_wide),
      .word_index (word_index),
      .even_in    (even_par),
      .odd_in     (odd_par),
      .even_out   (word_even),
      .odd_out    (word_odd)
   );

   // Software write wins over a word landing in the same cycle
   always @* begin
      next_even_par = even_par;
      next_odd_par  = odd_par;
      if (take_word) begin
         next_even_par = word_even;
         next_odd_par  = word_odd;
      end
      if (wr && (reg_sel == SEL_EVEN))
         next_even_par = pwdata[`NEP_PAR_MSB:0];
      if (wr && (reg_sel == SEL_ODD))
         next_odd_par = pwdata[`NEP_PAR_MSB:0];
   end

   // Counter wraps after 2048 words; longer blocks alias positions
   always @* begin
      next_word_index = word_index;
      if (take_word)
         next_word_index = word_index + 11'h001;
      if (start_req)
         next_word_index = 11'h000;
   end

   // Set and clear never meet: one bus access per cycle
   always @* begin
      next_start = select_two_parity_start;
      if (clear_start)
         next_start = 1'b0;
      if (start_req)
         next_start = 1'b1;
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Parity sets and word position
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         even_par   <= `NEP_PAR_RESET;
         odd_par    <= `NEP_PAR_RESET;
         word_index <= 11'h000;
      end else begin
         even_par   <= next_even_par;
         odd_par    <= next_odd_par;
         word_index <= next_word_index;
      end
   end

   // Width and NAND use change only by a control write
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         select_two_nand_enable  <= `NEP_NAND_RESET;
         bus_wide                <= 1'b0;
         select_two_parity_start <= 1'b0;
      end else begin
         select_two_parity_start <= next_start;
         if (ctrl_wr) begin
            select_two_nand_enable <= pwdata[`NEP_CTRL_NAND_BIT];
            bus_wide               <= pwdata[`NEP_CTRL_WIDE_BIT];
         end
      end
   end

   // ----------------------------------------------------------------
   // APB answer
   // ----------------------------------------------------------------
   // Zero-wait answer, registered so every output comes from a flop
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         // Unmapped addresses answer with an error and read as zero
         pslverr <= setup && (reg_sel == SEL_NONE);
         if (setup && !pwrite)
            prdata <= read_word(reg_sel, even_par, odd_par, bus_wide,
                                select_two_parity_start, select_two_nand_enable);
         else
            prdata <= 32'h0000_0000;
      end
   end
endmodule
`default_nettype wire

// ===== rtl/nep_parity_calc.v
// Combinational single-bit ECC parity update for one data word
`timescale 1ns/1ps
`default_nettype none
`include "nep_consts.vh"
module nep_parity_calc (
   input  wire [15:0]            data,
   input  wire                   wide,
   input  wire [10:0]            word_index,
   input  wire [`NEP_PAR_MSB:0]  even_in,
   input  wire [`NEP_PAR_MSB:0]  odd_in,
   output reg  [`NEP_PAR_MSB:0]  even_out,
   output reg  [`NEP_PAR_MSB:0]  odd_out
);
   // Bit index of data bit b within the flat bit stream: word_index * width + b
   reg [15:0] bit_addr;
   reg [15:0] row_addr;
   integer    b;
   integer    k;
   always @* begin
      bit_addr = 16'h0000;
      row_addr = 16'h0000;
      even_out = even_in;
      odd_out  = odd_in;
      for (b = 0; b < 16; b = b + 1) begin
         if (wide || b < 8) begin
            row_addr = wide ? {1'b0, word_index, 4'h0} : {2'b00, word_index, 3'h0};
            bit_addr = row_addr | b[15:0];
            for (k = 0; k < `NEP_PAR_W; k = k + 1) begin
               // Set bit k of position means odd parity group, clear means even
               if (bit_addr[k])
                  odd_out[k] = odd_out[k] ^ data[b];
               else
                  even_out[k] = even_out[k] ^ data[b];
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== test/nep_nand_model.sv
// Flash device on chip select two, one word per strobe
`timescale 1ns/1ps
`default_nettype none
module nep_nand_model (
   input  wire logic        pclk,
   output logic             memory_select_two,
   output logic             data_strobe,
   output logic [15:0]      nand_data
);
   initial begin
      memory_select_two = 0;
      data_strobe = 0;
      nand_data = 16'h0000;
   end
   task send(input [15:0] w);
      @(posedge pclk);
      memory_select_two <= 1; data_strobe <= 1; nand_data <= w;
      @(posedge pclk);
      // Released bus shows no stale word
      memory_select_two <= 0; data_strobe <= 0; nand_data <= ~w;
   endtask
endmodule
`default_nettype wire

// ===== test/nep_props.sv
// Port checker for the chip-select-two ECC parity block
`timescale 1ns/1ps
`default_nettype none
`include "nep_consts.vh"
module nep_props (
   input wire logic                   pclk,
   input wire logic                   presetn,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic                   pready,
   input wire logic                   pslverr,
   input wire logic [`NEP_ADDR_W-1:0] paddr,
   input wire logic [31:0]            pwdata,
   input wire logic [31:0]            prdata,
   input wire logic                   select_two_parity_start,
   input wire logic                   select_two_nand_enable
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire par = paddr == `NEP_BYTE_EVEN || paddr == `NEP_BYTE_ODD;
   wire nen_bit = pwdata[`NEP_CTRL_NAND_BIT];
   property p_idle; !pready |-> prdata == 32'h0000_0000 && !pslverr; endproperty
   a_idle: assert property (p_idle) else $error("read data outside answer");
   property p_nen; pready && pwrite && paddr == `NEP_BYTE_CTRL
      |=> select_two_nand_enable == $past(nen_bit); endproperty
   a_nen: assert property (p_nen) else $error("enable not written");
   property p_rdy; psel && !penable |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready after setup");
   property p_one; pready |=> !pready; endproperty
   a_one: assert property (p_one) else $error("ready held");
   property p_rsv; pready && !pwrite |-> prdata[31:12] == 20'h0_0000; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
   property p_map; pready && par |-> !pslverr; endproperty
   a_map: assert property (p_map) else $error("parity access refused");
   property p_clr; pready && !pwrite && par |=> !select_two_parity_start; endproperty
   a_clr: assert property (p_clr) else $error("start not cleared");
   property p_set; pready && pwrite && paddr == `NEP_BYTE_CTRL && pwdata[`NEP_CTRL_START_BIT]
      |=> select_two_parity_start; endproperty
   a_set: assert property (p_set) else $error("start not set");
   property p_src; $rose(select_two_parity_start) |-> $past(pwrite) && $past(pready);
   endproperty
   a_src: assert property (p_src) else $error("start set alone");
   property p_nand; $fell(select_two_nand_enable) |-> $past(pwrite) && $past(pready);
   endproperty
   a_nand: assert property (p_nand) else $error("enable dropped alone");
endmodule
bind nep_ecc_parity nep_props nep_props_inst (.pclk, .presetn, .psel, .penable, .pwrite,
   .pready, .pslverr, .paddr, .pwdata, .prdata, .select_two_parity_start,
   .select_two_nand_enable);
`default_nettype wire

// ===== test/tb.sv
// Bench for the chip-select-two ECC parity block
`timescale 1ns/1ps
`default_nettype none
`include "nep_consts.vh"
module tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [17:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rdat;
   logic pready, pslverr, rerr, cs2, stb, nen, st;
   logic [15:0] nd;
   integer fails = 0, cmp_count = 0, cyc = 0;
   always #10 pclk = ~pclk;
   nep_nand_model nep_nand_model_inst (.pclk(pclk), .memory_select_two(cs2),
      .data_strobe(stb), .nand_data(nd));
   nep_ecc_parity nep_ecc_parity_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .memory_select_two(cs2),
      .data_strobe(stb), .nand_data(nd), .select_two_nand_enable(nen),
      .select_two_parity_start(st));
   task summarize;
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin fails = fails + 1; summarize; end
   end
   task chk(input string n, input [31:0] e, g);
      cmp_count = cmp_count + 1;
      if (g !== e) begin fails = fails + 1; $display("MISMATCH %s exp %h got %h", n, e, g); end
   endtask
   task ap(input w, input [17:0] a, input [31:0] d);
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk); penable <= 1;
      // Request stands until pready is seen at a rising edge
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata; rerr = pslverr;
      psel <= 0; penable <= 0;
   endtask
   // Returns odd set above even set for one word at position n
   function [23:0] ecc(input [15:0] d, input [10:0] n, input w);
      integer b, k;
      ecc = 0;
      for (b = 0; b < (w ? 16 : 8); b++) if (d[b]) for (k = 0; k < 12; k++)
         if (((n * (w ? 16 : 8) + b) >> k) & 1) ecc[12+k] ^= 1; else ecc[k] ^= 1;
   endfunction
   task t_regs;
      ap(0, `NEP_BYTE_EVEN, 0); chk("even", 0, rdat);
      ap(0, `NEP_BYTE_CTRL, 0); chk("nand", 1, rdat[0]);
      chk("nen", 1, nen);
      ap(1, `NEP_BYTE_EVEN, '1); ap(0, `NEP_BYTE_EVEN, 0); chk("even", 'hFFF, rdat);
      ap(1, `NEP_BYTE_ODD, '1); ap(0, `NEP_BYTE_ODD, 0); chk("odd", 'hFFF, rdat);
      ap(0, 18'h0_0010, 0); chk("err", 1, rerr);
   endtask
   task t_par(input w, input en);
      logic [23:0] e;
      integer i;
      e = 0;
      ap(1, `NEP_BYTE_EVEN, 0); ap(1, `NEP_BYTE_ODD, 0);
      ap(1, `NEP_BYTE_CTRL, {w, 8'h80, en});
      // Flag lands on the access edge; look one edge later
      @(posedge pclk); chk("start", 1, st);
      chk("nen", en, nen);
      for (i = 0; i < 5; i++) begin
         nep_nand_model_inst.send(16'hC3A5 + i * 16'h1111);
         if (en) e ^= ecc(16'hC3A5 + i * 16'h1111, i, w);
      end
      ap(0, `NEP_BYTE_EVEN, 0); chk("even", e[11:0], rdat);
      ap(0, `NEP_BYTE_ODD, 0); chk("odd", e[23:12], rdat);
      ap(0, `NEP_BYTE_CTRL, 0); chk("start", 0, rdat[8]);
      // Words after the closing read must leave the parities alone
      nep_nand_model_inst.send(16'h00FF);
      ap(0, `NEP_BYTE_EVEN, 0); chk("hold", e[11:0], rdat);
   endtask
   task t_rst;
      ap(1, `NEP_BYTE_EVEN, 32'h0000_05A5);
      @(posedge pclk); presetn <= 0;
      repeat (8) @(posedge pclk);
      presetn <= 1;
      ap(0, `NEP_BYTE_EVEN, 0); chk("even", 0, rdat);
      ap(0, `NEP_BYTE_CTRL, 0); chk("ctrl", 1, rdat);
      chk("nen", 1, nen);
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1;
      t_regs;
      t_par(0, 1);
      t_par(1, 1);
      t_par(0, 0);
      t_rst;
      summarize;
   end
endmodule
`default_nettype wire
